// ===== dv/banked_config_register_file_bench.sv
// Self-checking bench for the banked register file, driving through the host model.
// Assumes the package constants and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module banked_config_register_file_bench;
  import bcrf_pkg::*;
  logic                  core_clk_i;
  logic                  rstn_i;
  logic                  strap;
  logic [10:0]           irq;
  bcrf_io_req_t          req;
  logic                  hit, ext_wr, ext_rd, wake;
  logic [7:0]            rdata, ext_idx, ext_wd, ext_rd_data;
  bcrf_func_cfg_t [10:0] cfg;
  int                    miscompares;
  int                    check_count;
  int                    ext_rd_seen = 0;

  bcrf_regfile dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .base_address_strap_i(strap),
    .io_req_i(req), .io_hit_o(hit), .io_rdata_o(rdata), .ext_wr_o(ext_wr),
    .ext_rd_o(ext_rd), .ext_index_o(ext_idx), .ext_wdata_o(ext_wd),
    .ext_rdata_i(ext_rd_data), .func_irq_i(irq), .func_cfg_o(cfg), .wake_event_o(wake));

  bcrf_host_model host (.core_clk_i(core_clk_i), .io_req_o(req), .io_hit_i(hit),
    .io_rdata_i(rdata), .ext_wr_i(ext_wr), .ext_index_i(ext_idx), .ext_wdata_i(ext_wd),
    .ext_rdata_o(ext_rd_data));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (ext_rd) ext_rd_seen++;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic expect_reg(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    host.get_reg(idx, q);
    check(what, 16'(exp), 16'(q));
  endtask : expect_reg

  task automatic do_reset(input logic s);
    rstn_i = 1'b0;
    strap  = s;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rstn_i = 1'b1;
  endtask : do_reset

  // A cycle after a rising edge of the irq line, wake must equal exp, and be low one cycle later
  task automatic irq_rise(input int b, input logic exp);
    @(negedge core_clk_i);
    irq[b] = 1'b1;
    @(negedge core_clk_i);
    check("wake pulse", 16'(exp), 16'(wake));
    @(negedge core_clk_i);
    check("wake end", 16'h0000, 16'(wake));
    irq[b] = 1'b0;
  endtask : irq_rise

  initial begin
    #100000;
    miscompares++;
    final_report();
  end

  initial begin
    logic       h;
    logic [7:0] q;
    logic       act;
    miscompares = 0;
    check_count = 0;
    irq = '0;
    do_reset(1'b0);
    host.cycle(1'b0, 16'h002e, 8'h00, h, q);
    check("index reset", 16'h0000, 16'(q));
    check("hit low base", 16'h0001, 16'(h));
    expect_reg("bank sel reset", BCRF_IDX_BANK_SEL, 8'h00);
    expect_reg("floppy inactive", BCRF_IDX_ACTIVATE, 8'h00);
    host.set_reg(BCRF_IDX_BANK_SEL, BCRF_BANK_KEYBOARD);
    expect_reg("keyboard active", BCRF_IDX_ACTIVATE, 8'h01);
    check("keyboard cfg", 16'h0001, 16'(cfg[6].active));
    for (int b = 0; b < 11; b++) begin
      host.set_reg(BCRF_IDX_BANK_SEL, 8'(b));
      host.set_reg(BCRF_IDX_ACTIVATE, b[0] ? 8'hfe : 8'hff);
      for (int k = 0; k < 4; k++) host.set_reg(8'(8'h60 + k), 8'(16 * (k + 1) + b));
      host.set_reg(BCRF_IDX_IRQ_NUM, 8'hf0 | 8'(b));
      host.set_reg(BCRF_IDX_IRQ_TYPE, 8'hfc | 8'(b[2:1]));
    end
    // Every bank carries its own values, so any crossing between copies shows up
    for (int b = 0; b < 11; b++) begin
      act = ~b[0];
      host.set_reg(BCRF_IDX_BANK_SEL, 8'(b));
      expect_reg("activate", BCRF_IDX_ACTIVATE, {7'h00, act});
      for (int k = 0; k < 4; k++) begin
        expect_reg("io base byte", 8'(8'h60 + k), 8'(16 * (k + 1) + b));
      end
      expect_reg("irq number", BCRF_IDX_IRQ_NUM, 8'h10 | 8'(b));
      expect_reg("irq type", BCRF_IDX_IRQ_TYPE, 8'(b[2:1]));
      check("cfg active", 16'(act), 16'(cfg[b].active));
      check("cfg base0", act ? 16'(16'h1020 + 16'h0101 * b) : 16'h0000,
            cfg[b].base0);
      check("cfg base1", act ? 16'(16'h3040 + 16'h0101 * b) : 16'h0000,
            cfg[b].base1);
      check("cfg irq line", act ? 16'(b) : 16'h0000, 16'(cfg[b].irq_line));
      if (act) begin
        check("cfg polarity", 16'(b[2]), 16'(cfg[b].irq_high));
        check("cfg level", 16'(b[1]), 16'(cfg[b].irq_level));
        check("cfg wake", 16'h0001, 16'(cfg[b].wake_en));
      end
    end
    host.set_reg(BCRF_IDX_BANK_SEL, BCRF_BANK_SERIAL2);
    host.set_reg(8'h40, 8'h5a);
    expect_reg("absent reg", 8'h40, BCRF_RD_NONE);
    expect_reg("reserved index", 8'h31, BCRF_RD_NONE);
    expect_reg("low absent", 8'h10, BCRF_RD_NONE);
    host.set_reg(BCRF_IDX_DMA0, 8'hab);
    expect_reg("dma0", BCRF_IDX_DMA0, BCRF_RD_NO_DMA);
    expect_reg("dma1", BCRF_IDX_DMA1, BCRF_RD_NO_DMA);
    host.set_reg(BCRF_IDX_BANK_SEL, 8'h0b);
    expect_reg("reserved bank sel", BCRF_IDX_BANK_SEL, 8'h0b);
    host.set_reg(BCRF_IDX_BASE0_HI, 8'hee);
    expect_reg("reserved bank read", BCRF_IDX_BASE0_HI, BCRF_RD_NONE);
    host.set_reg(BCRF_IDX_BANK_SEL, BCRF_BANK_SERIAL2);
    expect_reg("bank untouched", BCRF_IDX_BASE0_HI, 8'h12);
    host.set_reg(BCRF_IDX_BANK_SEL, BCRF_BANK_SERIAL1);
    host.set_reg(8'h25, 8'ha5);
    host.set_reg(BCRF_IDX_BANK_SEL, BCRF_BANK_MOUSE);
    expect_reg("global unbanked", 8'h25, 8'ha5);
    check("global read strobe", 16'h0001, 16'(ext_rd_seen));
    host.set_reg(BCRF_IDX_BANK_SEL, BCRF_BANK_SERIAL2);
    host.rmw(BCRF_IDX_IRQ_NUM, 8'h0f, 8'h03);
    expect_reg("rmw keeps wake", BCRF_IDX_IRQ_NUM, 8'h13);
    irq_rise(2, 1'b1);
    irq_rise(1, 1'b0);
    host.set_reg(BCRF_IDX_IRQ_NUM, 8'h03);
    irq_rise(2, 1'b0);
    do_reset(1'b1);
    repeat (2) @(posedge core_clk_i);
    host.port_base = BCRF_CFG_BASE_HI;
    host.cycle(1'b0, 16'h002e, 8'h00, h, q);
    check("old base ignored", 16'h0000, 16'(h));
    host.set_reg(BCRF_IDX_BANK_SEL, BCRF_BANK_FAN);
    host.cycle(1'b0, BCRF_CFG_BASE_HI, 8'h00, h, q);
    check("index readback", 16'(BCRF_IDX_BANK_SEL), 16'(q));
    expect_reg("bank at high base", BCRF_IDX_BANK_SEL, BCRF_BANK_FAN);
    final_report();
  end
endmodule : banked_config_register_file_bench
`default_nettype wire

// ===== dv/bcrf_host_model.sv
// Host bridge model: byte I/O cycles toward the register file, plus the global
// register store that answers the ext port. Assumes one clock and negedge driving.
`timescale 1ns/1ps
`default_nettype none
module bcrf_host_model
  import bcrf_pkg::*;
(
  input  wire logic         core_clk_i,
  output bcrf_io_req_t      io_req_o,
  input  wire logic         io_hit_i,
  input  wire logic [7:0]   io_rdata_i,
  input  wire logic         ext_wr_i,
  input  wire logic [7:0]   ext_index_i,
  input  wire logic [7:0]   ext_wdata_i,
  output logic [7:0]        ext_rdata_o
);
  logic [7:0]  glob [16];
  logic [15:0] port_base;

  initial begin
    io_req_o  = '0;
    port_base = BCRF_CFG_BASE_LO;
    for (int i = 0; i < 16; i++) glob[i] = 8'h00;
  end

  assign ext_rdata_o = glob[ext_index_i[3:0]];

  always @(posedge core_clk_i) begin
    if (ext_wr_i) glob[ext_index_i[3:0]] <= ext_wdata_i;
  end

  // One cycle; released lines show the inverse so a stale value cannot pass
  task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic hit, output logic [7:0] q);
    @(negedge core_clk_i);
    io_req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    #1 hit = io_hit_i;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    q = io_rdata_i;
    io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : cycle

  task automatic set_reg(input logic [7:0] idx, input logic [7:0] d);
    logic       h;
    logic [7:0] q;
    cycle(1'b1, port_base, idx, h, q);
    cycle(1'b1, port_base + 16'h0001, d, h, q);
  endtask : set_reg

  task automatic get_reg(input logic [7:0] idx, output logic [7:0] q);
    logic h;
    cycle(1'b1, port_base, idx, h, q);
    cycle(1'b0, port_base + 16'h0001, 8'h00, h, q);
  endtask : get_reg

  // Keeps bits outside the mask, so reserved and wake bits survive; no
  // write-only register exists here, so read-back is always meaningful
  task automatic rmw(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] v);
    logic [7:0] q;
    get_reg(idx, q);
    set_reg(idx, (q & ~mask) | (v & mask));
  endtask : rmw
endmodule : bcrf_host_model
`default_nettype wire

// ===== hdl/bcrf_bank.sv
// One function block's bank of standard configuration registers.
// Assumes the parent gives a one-cycle write strobe already qualified by bank select.
`timescale 1ns/1ps
`default_nettype none
module bcrf_bank
  import bcrf_pkg::*;
#(
  parameter logic [7:0] ACT_RESET  = 8'h00,
  parameter logic       TYPE_FIXED = 1'b0
) (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] index_i,
  input  wire logic [7:0] wdata_i,
  output bcrf_bank_t      regs_o
);

  bcrf_bank_t st;
  bcrf_bank_t next_st;

  always_comb begin
    next_st = st;
    if (wr_i) begin
      case (index_i)
        BCRF_IDX_ACTIVATE: next_st.activate = wdata_i & BCRF_ACT_MASK;
        BCRF_IDX_BASE0_HI: next_st.base0_hi = wdata_i;
        BCRF_IDX_BASE0_LO: next_st.base0_lo = wdata_i;
        BCRF_IDX_BASE1_HI: next_st.base1_hi = wdata_i;
        BCRF_IDX_BASE1_LO: next_st.base1_lo = wdata_i;
        BCRF_IDX_IRQ_NUM:  next_st.irq_num  = wdata_i & BCRF_IRQ_NUM_MASK;
        BCRF_IDX_IRQ_TYPE: begin
          // A block with a single interrupt type keeps its reset value
          if (!TYPE_FIXED) begin
            next_st.irq_type = wdata_i & BCRF_IRQ_TYPE_MASK;
          end
        end
        default: next_st = st;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st          <= '0;
      st.activate <= ACT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign regs_o = st;

endmodule : bcrf_bank
`default_nettype wire

// ===== hdl/bcrf_regfile.sv
// Banked configuration register file reached through an index/data port pair.
// Assumes the host bridge presents single-cycle byte reads and writes on core_clk_i;
// global registers at 20h-2Fh live outside and are reached through the ext port.
//
// What this block does
// - Bank-select register at index 07h picks the bank for banked accesses.
// - Each of 11 function blocks has its own copy of banked registers.
// - Data accesses at index 30h or above reach that register in selected bank.
// - Global registers, including 20h-2Fh, are unbanked and reached directly.
// - Bank values 00h-0Ah map to eleven blocks in fixed order; others reserved.
// - Data writes to nonexistent registers are dropped with no effect.
// - Reads of nonexistent registers return 00h, but 04h at 74h and 75h.
// - Registers accept accesses right after reset release; code decodes only 2Eh/2Fh until the first clock after release latches the strap.
// - Reserved bits read as zero.
// - Banked registers are readable and writable unless stated otherwise.
// - Bit 0 at index 30h activates the selected block; bits 7-1 reserved.
// - Indexes 60h/61h hold upper/lower byte of first I/O base.
// - Indexes 62h/63h hold upper/lower byte of second I/O base.
// - Bits 3-0 of interrupt register pick line 1-15; zero means none.
// - Bit 4 at 70h enables wake on interrupt, default 0.
// - Bit 1 at 71h gives interrupt polarity: 0 low, 1 high.
// - Bit 0 of type register: 0 edge, 1 level; bits 7-2 reserved.
// - Type register may be read-only for single-type blocks.
// - Index register points at the register reached through the data port.
// - Index register reads back last written value, 00h after reset.
// - An active block gets its resources; inactive blocks leave them unused.
// - Index/data pair sits at 2Eh/2Fh or 4Eh/4Fh by reset strap.
`timescale 1ns/1ps
`default_nettype none
module bcrf_regfile
  import bcrf_pkg::*;
#(
  parameter int unsigned NUM_BANKS = BCRF_NUM_BANKS
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  base_address_strap_i,
  input  wire bcrf_io_req_t          io_req_i,
  output logic                       io_hit_o,
  output logic [7:0]                 io_rdata_o,
  output logic                       ext_wr_o,
  output logic                       ext_rd_o,
  output logic [7:0]                 ext_index_o,
  output logic [7:0]                 ext_wdata_o,
  input  wire logic [7:0]            ext_rdata_i,
  input  wire logic [NUM_BANKS-1:0]  func_irq_i,
  output bcrf_func_cfg_t [NUM_BANKS-1:0] func_cfg_o,
  output logic                       wake_event_o
);

  typedef struct packed {
    logic                 strap_taken;
    logic                 cfg_base_hi;
    logic [7:0]           index;
    logic [7:0]           bank_sel;
    logic [7:0]           rdata;
    logic [NUM_BANKS-1:0] irq_prev;
    logic                 wake;
  } bcrf_top_st_t;

  bcrf_top_st_t st;
  bcrf_top_st_t next_st;

  logic                       strap_sync;
  bcrf_bank_t [NUM_BANKS-1:0] bank_regs;
  logic [NUM_BANKS-1:0]       bank_wr;

  logic [15:0] cfg_base;
  logic        hit_index;
  logic        hit_data;
  logic        bank_valid;
  logic        banked_idx;
  logic        global_idx;
  logic [7:0]  data_rd;
  bcrf_bank_t  cur_bank;

  bcrf_sync2 u_strap_sync (
    .core_clk_i (core_clk_i),
    .async_i    (base_address_strap_i),
    .sync_o     (strap_sync)
  );

  // One bank per function block; the keyboard bank comes up active
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    bcrf_bank #(
      .ACT_RESET  ((b == int'(BCRF_BANK_KEYBOARD)) ? BCRF_ACT_MASK : 8'h00),
      .TYPE_FIXED (1'b0)
    ) u_bank (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .wr_i       (bank_wr[b]),
      .index_i    (st.index),
      .wdata_i    (io_req_i.wdata),
      .regs_o     (bank_regs[b])
    );
  end

  // Strap is latched once after reset; until then the low pair decodes
  assign cfg_base  = st.cfg_base_hi ? BCRF_CFG_BASE_HI : BCRF_CFG_BASE_LO;
  assign hit_index = (io_req_i.addr == cfg_base);
  assign hit_data  = (io_req_i.addr == (cfg_base + 16'h0001));
  assign io_hit_o  = hit_index || hit_data;

  assign bank_valid = (st.bank_sel < 8'(NUM_BANKS));
  assign banked_idx = (st.index >= BCRF_IDX_BANKED_LO);
  assign global_idx = (st.index >= BCRF_IDX_GLOBAL_LO) &&
                      (st.index <= BCRF_IDX_GLOBAL_HI);

  always_comb begin
    cur_bank = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (st.bank_sel == 8'(i)) begin
        cur_bank = bank_regs[i];
      end
    end
  end

  // Writes reach only the selected bank's copy
  always_comb begin
    bank_wr = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      bank_wr[i] = io_req_i.wr && hit_data && banked_idx &&
                   (st.bank_sel == 8'(i));
    end
  end

  // Global window is passed outward untouched by bank selection
  assign ext_wr_o    = io_req_i.wr && hit_data && global_idx;
  assign ext_rd_o    = io_req_i.rd && hit_data && global_idx;
  assign ext_index_o = st.index;
  assign ext_wdata_o = io_req_i.wdata;

  always_comb begin
    data_rd = BCRF_RD_NONE;
    if (st.index == BCRF_IDX_BANK_SEL) begin
      data_rd = st.bank_sel;
    end else if (global_idx) begin
      data_rd = ext_rdata_i;
    end else if (banked_idx && bank_valid) begin
      case (st.index)
        BCRF_IDX_ACTIVATE: data_rd = cur_bank.activate;
        BCRF_IDX_BASE0_HI: data_rd = cur_bank.base0_hi;
        BCRF_IDX_BASE0_LO: data_rd = cur_bank.base0_lo;
        BCRF_IDX_BASE1_HI: data_rd = cur_bank.base1_hi;
        BCRF_IDX_BASE1_LO: data_rd = cur_bank.base1_lo;
        BCRF_IDX_IRQ_NUM:  data_rd = cur_bank.irq_num;
        BCRF_IDX_IRQ_TYPE: data_rd = cur_bank.irq_type;
        BCRF_IDX_DMA0:     data_rd = BCRF_RD_NO_DMA;
        BCRF_IDX_DMA1:     data_rd = BCRF_RD_NO_DMA;
        default:           data_rd = BCRF_RD_NONE;
      endcase
    end else if (banked_idx &&
                 ((st.index == BCRF_IDX_DMA0) || (st.index == BCRF_IDX_DMA1))) begin
      data_rd = BCRF_RD_NO_DMA;
    end
  end

  always_comb begin
    next_st = st;
    if (!st.strap_taken) begin
      next_st.strap_taken = 1'b1;
      next_st.cfg_base_hi = strap_sync;
    end
    if (io_req_i.wr && hit_index) begin
      next_st.index = io_req_i.wdata;
    end
    if (io_req_i.wr && hit_data && (st.index == BCRF_IDX_BANK_SEL)) begin
      next_st.bank_sel = io_req_i.wdata;
    end
    if (io_req_i.rd && hit_index) begin
      next_st.rdata = st.index;
    end else if (io_req_i.rd && hit_data) begin
      next_st.rdata = data_rd;
    end
    next_st.irq_prev = func_irq_i;
    next_st.wake     = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (func_irq_i[i] && !st.irq_prev[i] &&
          bank_regs[i].irq_num[BCRF_WAKE_BIT] &&
          bank_regs[i].activate[BCRF_ACT_BIT]) begin
        next_st.wake = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st          <= '0;
      st.index    <= BCRF_INDEX_RESET;
      st.bank_sel <= BCRF_BANK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign io_rdata_o   = st.rdata;
  assign wake_event_o = st.wake;

  // Resources are withheld from a block that is not active
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      func_cfg_o[i].active    = bank_regs[i].activate[BCRF_ACT_BIT];
      func_cfg_o[i].base0     = func_cfg_o[i].active ?
                                {bank_regs[i].base0_hi, bank_regs[i].base0_lo} : 16'h0000;
      func_cfg_o[i].base1     = func_cfg_o[i].active ?
                                {bank_regs[i].base1_hi, bank_regs[i].base1_lo} : 16'h0000;
      func_cfg_o[i].irq_line  = func_cfg_o[i].active ?
                                bank_regs[i].irq_num[3:0] : 4'h0;
      func_cfg_o[i].irq_high  = bank_regs[i].irq_type[BCRF_POL_BIT];
      func_cfg_o[i].irq_level = bank_regs[i].irq_type[BCRF_TYPE_BIT];
      func_cfg_o[i].wake_en   = bank_regs[i].irq_num[BCRF_WAKE_BIT];
    end
  end

  default clocking chk_clk @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Data-port accesses that land in a valid bank, for the checks below
  logic sel_wr;
  logic sel_rd;
  assign sel_wr = io_req_i.wr && hit_data && banked_idx && bank_valid;
  assign sel_rd = io_req_i.rd && hit_data && banked_idx && bank_valid;

  index_readback_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    io_req_i.wr && hit_index ##1 io_req_i.rd && hit_index |=> io_rdata_o == $past(st.index))
    else $error("index readback wrong");

  dma_default_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    io_req_i.rd && hit_data && banked_idx &&
    ((st.index == BCRF_IDX_DMA0) || (st.index == BCRF_IDX_DMA1))
    |=> io_rdata_o == BCRF_RD_NO_DMA)
    else $error("dma read not 04h");

  bank_isolate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    bank_wr != '0 |-> $onehot(bank_wr) && bank_valid)
    else $error("write reached several banks");

  reserved_act_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    io_req_i.rd && hit_data && st.index == BCRF_IDX_ACTIVATE
    |=> io_rdata_o[7:1] == 7'h00)
    else $error("activate reserved bits set");

  bank_select_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    io_req_i.wr && hit_data && st.index == BCRF_IDX_BANK_SEL
    |=> st.bank_sel == $past(io_req_i.wdata))
    else $error("bank select not stored");

  global_pass_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    io_req_i.wr && hit_data && global_idx |-> ext_wr_o && bank_wr == '0)
    else $error("global write misrouted");

  unknown_drop_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    io_req_i.wr && hit_data && !banked_idx && !global_idx &&
    st.index != BCRF_IDX_BANK_SEL |=> $stable(st.bank_sel) && $stable(bank_regs))
    else $error("dropped write changed state");

  wake_cause_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wake_event_o |-> $past(|(func_irq_i & ~st.irq_prev)))
    else $error("wake without interrupt edge");

  inactive_free_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !func_cfg_o[0].active |-> func_cfg_o[0].base0 == 16'h0000 && func_cfg_o[0].irq_line == 4'h0)
    else $error("inactive block holds resources");

  idx_write_a: assert property (
    io_req_i.wr && hit_index |=> st.index == $past(io_req_i.wdata))
    else $error("index write lost");

  bank_route_a: assert property (
    sel_wr |-> bank_wr[st.bank_sel[3:0]])
    else $error("banked write not routed");

  reserved_read_a: assert property (
    io_req_i.rd && hit_data && banked_idx && !bank_valid &&
    st.index != BCRF_IDX_DMA0 && st.index != BCRF_IDX_DMA1 |=> io_rdata_o == BCRF_RD_NONE)
    else $error("reserved bank read not zero");

  absent_read_a: assert property (
    io_req_i.rd && hit_data && st.index < BCRF_IDX_GLOBAL_LO &&
    st.index != BCRF_IDX_BANK_SEL |=> io_rdata_o == BCRF_RD_NONE)
    else $error("absent register read not zero");

  global_read_a: assert property (
    io_req_i.rd && hit_data && global_idx |-> ext_rd_o ##1 io_rdata_o == $past(ext_rdata_i))
    else $error("global read misrouted");

  act_store_a: assert property (
    sel_wr && st.index == BCRF_IDX_ACTIVATE
    |=> cur_bank.activate == ($past(io_req_i.wdata) & BCRF_ACT_MASK))
    else $error("activate not stored");

  base0_hi_a: assert property (
    sel_wr && st.index == BCRF_IDX_BASE0_HI |=> cur_bank.base0_hi == $past(io_req_i.wdata))
    else $error("base0 high not stored");

  base0_lo_a: assert property (
    sel_wr && st.index == BCRF_IDX_BASE0_LO |=> cur_bank.base0_lo == $past(io_req_i.wdata))
    else $error("base0 low not stored");

  base1_hi_a: assert property (
    sel_wr && st.index == BCRF_IDX_BASE1_HI |=> cur_bank.base1_hi == $past(io_req_i.wdata))
    else $error("base1 high not stored");

  base1_lo_a: assert property (
    sel_wr && st.index == BCRF_IDX_BASE1_LO |=> cur_bank.base1_lo == $past(io_req_i.wdata))
    else $error("base1 low not stored");

  irq_store_a: assert property (
    sel_wr && st.index == BCRF_IDX_IRQ_NUM
    |=> cur_bank.irq_num == ($past(io_req_i.wdata) & BCRF_IRQ_NUM_MASK))
    else $error("irq number not stored");

  type_store_a: assert property (
    sel_wr && st.index == BCRF_IDX_IRQ_TYPE
    |=> cur_bank.irq_type == ($past(io_req_i.wdata) & BCRF_IRQ_TYPE_MASK))
    else $error("irq type not stored");

  type_reserved_a: assert property (
    io_req_i.rd && hit_data && st.index == BCRF_IDX_IRQ_TYPE |=> io_rdata_o[7:2] == 6'h00)
    else $error("irq type reserved bits set");

  irq_reserved_a: assert property (
    io_req_i.rd && hit_data && st.index == BCRF_IDX_IRQ_NUM |=> io_rdata_o[7:5] == 3'h0)
    else $error("irq number reserved bits set");

  base_readback_a: assert property (
    sel_rd && st.index == BCRF_IDX_BASE1_LO |=> io_rdata_o == $past(cur_bank.base1_lo))
    else $error("base1 low read wrong");

  wake_on_irq_a: assert property (
    $rose(func_irq_i[2]) && func_cfg_o[2].wake_en && func_cfg_o[2].active |=> wake_event_o)
    else $error("wake missing after interrupt");

  strap_hold_a: assert property (
    st.strap_taken |=> $stable(st.cfg_base_hi))
    else $error("port base moved after latch");

  dma_drop_a: assert property (
    io_req_i.wr && hit_data &&
    (st.index == BCRF_IDX_DMA0 || st.index == BCRF_IDX_DMA1) |=> $stable(bank_regs))
    else $error("dma write changed state");

  bank_sel_read_a: assert property (
    io_req_i.rd && hit_data && st.index == BCRF_IDX_BANK_SEL
    |=> io_rdata_o == $past(st.bank_sel))
    else $error("bank select read wrong");

  other_bank_a: assert property (
    io_req_i.wr && hit_data && st.bank_sel != BCRF_BANK_FLOPPY |=> $stable(bank_regs[0]))
    else $error("write reached unselected bank");

endmodule : bcrf_regfile
`default_nettype wire

// ===== hdl/bcrf_sync2.sv
// Two-stage synchroniser for a level that arrives from a pin.
// Assumes the input is quasi-static relative to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module bcrf_sync2
  import bcrf_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic async_i,
  output logic      sync_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } bcrf_sync_st_t;

  bcrf_sync_st_t st;
  bcrf_sync_st_t next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = async_i;
    next_st.sync = st.meta;
  end

  // Kept out of reset so the strap level has passed both stages when reset ends
  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  assign sync_o = st.sync;

endmodule : bcrf_sync2
`default_nettype wire

// ===== inc/bcrf_pkg.sv
// Package for the banked configuration register file: offsets, field layout and the
// access carrier shared by the register file and its helpers.
// Assumes a single 100 MHz clock domain and a byte-wide host I/O cycle interface.
package bcrf_pkg;

  localparam int unsigned BCRF_NUM_BANKS = 11;

  localparam logic [15:0] BCRF_CFG_BASE_LO = 16'h002e;
  localparam logic [15:0] BCRF_CFG_BASE_HI = 16'h004e;

  localparam logic [7:0] BCRF_IDX_BANK_SEL  = 8'h07;
  localparam logic [7:0] BCRF_IDX_GLOBAL_LO = 8'h20;
  localparam logic [7:0] BCRF_IDX_GLOBAL_HI = 8'h2f;
  localparam logic [7:0] BCRF_IDX_BANKED_LO = 8'h30;
  localparam logic [7:0] BCRF_IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0] BCRF_IDX_BASE0_HI  = 8'h60;
  localparam logic [7:0] BCRF_IDX_BASE0_LO  = 8'h61;
  localparam logic [7:0] BCRF_IDX_BASE1_HI  = 8'h62;
  localparam logic [7:0] BCRF_IDX_BASE1_LO  = 8'h63;
  localparam logic [7:0] BCRF_IDX_IRQ_NUM   = 8'h70;
  localparam logic [7:0] BCRF_IDX_IRQ_TYPE  = 8'h71;
  localparam logic [7:0] BCRF_IDX_DMA0      = 8'h74;
  localparam logic [7:0] BCRF_IDX_DMA1      = 8'h75;

  localparam logic [7:0] BCRF_RD_NONE       = 8'h00;
  localparam logic [7:0] BCRF_RD_NO_DMA     = 8'h04;

  localparam logic [7:0] BCRF_INDEX_RESET   = 8'h00;
  localparam logic [7:0] BCRF_BANK_RESET    = 8'h00;
  localparam logic [7:0] BCRF_ACT_MASK      = 8'h01;
  localparam logic [7:0] BCRF_IRQ_NUM_MASK  = 8'h1f;
  localparam logic [7:0] BCRF_IRQ_TYPE_MASK = 8'h03;
  localparam int unsigned BCRF_ACT_BIT       = 0;
  localparam int unsigned BCRF_WAKE_BIT      = 4;
  localparam int unsigned BCRF_POL_BIT       = 1;
  localparam int unsigned BCRF_TYPE_BIT      = 0;

  // Bank numbers of the function blocks
  localparam logic [7:0] BCRF_BANK_FLOPPY   = 8'h00;
  localparam logic [7:0] BCRF_BANK_PARALLEL = 8'h01;
  localparam logic [7:0] BCRF_BANK_SERIAL2  = 8'h02;
  localparam logic [7:0] BCRF_BANK_SERIAL1  = 8'h03;
  localparam logic [7:0] BCRF_BANK_WAKE     = 8'h04;
  localparam logic [7:0] BCRF_BANK_MOUSE    = 8'h05;
  localparam logic [7:0] BCRF_BANK_KEYBOARD = 8'h06;
  localparam logic [7:0] BCRF_BANK_GPIO     = 8'h07;
  localparam logic [7:0] BCRF_BANK_TWO_WIRE = 8'h08;
  localparam logic [7:0] BCRF_BANK_FAN      = 8'h09;
  localparam logic [7:0] BCRF_BANK_WATCHDOG = 8'h0a;

  // Per-bank standard registers
  typedef struct packed {
    logic [7:0] activate;
    logic [7:0] base0_hi;
    logic [7:0] base0_lo;
    logic [7:0] base1_hi;
    logic [7:0] base1_lo;
    logic [7:0] irq_num;
    logic [7:0] irq_type;
  } bcrf_bank_t;

  // One byte cycle from the host bridge
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bcrf_io_req_t;

  // Settings a bank hands to its function block
  typedef struct packed {
    logic        active;
    logic [15:0] base0;
    logic [15:0] base1;
    logic [3:0]  irq_line;
    logic        irq_high;
    logic        irq_level;
    logic        wake_en;
  } bcrf_func_cfg_t;

endpackage : bcrf_pkg
